// ---- hw/iod_pkg.sv ----
package iod_pkg;

  // ==========================================================
  // Address spaces
  localparam logic [7:0] PORT_LAST          = 8'h3F;
  localparam logic [7:0] BIT_LAST           = 8'h1F;
  localparam logic [7:0] IO_DATA_OFFSET     = 8'h20;
  localparam int         DATA_IO_BASE       = 32;
  localparam int         DATA_LAST          = 255;
  localparam logic [7:0] RESET_VALUE        = 8'h00;
  localparam logic [7:0] ALL_BITS           = 8'hFF;
  localparam logic [7:0] NO_BITS            = 8'h00;
  localparam logic [7:0] ONE_BIT            = 8'h01;

  // ==========================================================
  // Data-space addresses of the mapped registers
  localparam logic [7:0] PORT_B_PIN_INPUT      = 8'h23;
  localparam logic [7:0] PORT_B_DIRECTION      = 8'h24;
  localparam logic [7:0] PORT_B_OUTPUT         = 8'h25;
  localparam logic [7:0] PORT_C_PIN_INPUT      = 8'h26;
  localparam logic [7:0] PORT_C_DIRECTION      = 8'h27;
  localparam logic [7:0] PORT_C_OUTPUT         = 8'h28;
  localparam logic [7:0] PORT_D_PIN_INPUT      = 8'h29;
  localparam logic [7:0] PORT_D_DIRECTION      = 8'h2A;
  localparam logic [7:0] PORT_D_OUTPUT         = 8'h2B;
  localparam logic [7:0] TIMER0_FLAGS          = 8'h35;
  localparam logic [7:0] TIMER1_FLAGS          = 8'h36;
  localparam logic [7:0] TIMER2_FLAGS          = 8'h37;
  localparam logic [7:0] PIN_CHANGE_FLAGS      = 8'h3B;
  localparam logic [7:0] EXTERNAL_IRQ_FLAGS    = 8'h3C;
  localparam logic [7:0] EXTERNAL_IRQ_MASK     = 8'h3D;
  localparam logic [7:0] NVM_ADDRESS_LOW       = 8'h41;
  localparam logic [7:0] NVM_ADDRESS_HIGH      = 8'h42;
  localparam logic [7:0] TIMER_GENERAL_CONTROL = 8'h43;
  localparam logic [7:0] TIMER0_CONTROL_A      = 8'h44;
  localparam logic [7:0] TIMER0_CONTROL_B      = 8'h45;
  localparam logic [7:0] TIMER0_COUNT          = 8'h46;
  localparam logic [7:0] TIMER0_COMPARE_A      = 8'h47;
  localparam logic [7:0] TIMER0_COMPARE_B      = 8'h48;
  localparam logic [7:0] SCRATCH_REGISTER_ONE  = 8'h4A;
  localparam logic [7:0] SCRATCH_REGISTER_TWO  = 8'h4B;
  localparam logic [7:0] SERIAL_PERIPH_CONTROL = 8'h4C;
  localparam logic [7:0] SERIAL_PERIPH_STATUS  = 8'h4D;
  localparam logic [7:0] SERIAL_PERIPH_DATA    = 8'h4E;
  localparam logic [7:0] COMPARATOR_CTRL_STAT  = 8'h50;
  localparam logic [7:0] SLEEP_MODE_CONTROL    = 8'h53;
  localparam logic [7:0] RESET_CAUSE_STATUS    = 8'h54;
  localparam logic [7:0] CORE_CONTROL          = 8'h55;
  localparam logic [7:0] SELF_PROGRAM_CONTROL  = 8'h57;
  localparam logic [7:0] STACK_POINTER_LOW     = 8'h5D;
  localparam logic [7:0] STACK_POINTER_HIGH    = 8'h5E;
  localparam logic [7:0] CORE_STATUS_FLAGS     = 8'h5F;
  localparam logic [7:0] WATCHDOG_CTRL_STAT    = 8'h60;
  localparam logic [7:0] CLOCK_PRESCALE        = 8'h61;
  localparam logic [7:0] POWER_REDUCTION       = 8'h64;
  localparam logic [7:0] OSCILLATOR_TRIM       = 8'h66;
  localparam logic [7:0] PIN_CHANGE_IRQ_CTRL   = 8'h68;
  localparam logic [7:0] EXT_IRQ_SENSE_CTRL    = 8'h69;
  localparam logic [7:0] PIN_CHANGE_MASK_0     = 8'h6B;
  localparam logic [7:0] PIN_CHANGE_MASK_1     = 8'h6C;
  localparam logic [7:0] PIN_CHANGE_MASK_2     = 8'h6D;
  localparam logic [7:0] TIMER0_IRQ_MASK       = 8'h6E;
  localparam logic [7:0] TIMER1_IRQ_MASK       = 8'h6F;
  localparam logic [7:0] TIMER2_IRQ_MASK       = 8'h70;

  // ==========================================================
  // Access kinds issued by the core
  typedef enum logic [2:0] {
    port_read_op,
    port_write_op,
    data_space_load,
    data_space_write_op,
    bit_set_op,
    bit_clear_op,
    skip_if_bit_set_op,
    skip_if_bit_clear_op
  } iod_kind_type;

endpackage

// ---- hw/iod_io_register_space_decoder.sv ----
`timescale 1ns/1ps
module iod_io_register_space_decoder (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Core request
  input  wire logic                req_valid,
  input  wire iod_pkg::iod_kind_type req_kind,
  input  wire logic [7:0]          req_addr,
  input  wire logic [2:0]          req_bit,
  input  wire logic [7:0]          req_wdata,
  // Core answer
  output logic                     rsp_valid_q,
  output logic [7:0]               rsp_rdata_q,
  output logic                     rsp_skip_q,
  output logic                     rsp_reject_q,
  // Hardware flag set events
  input  wire logic [7:0]          timer0_flag_set,
  input  wire logic [7:0]          timer1_flag_set,
  input  wire logic [7:0]          timer2_flag_set,
  input  wire logic [7:0]          pin_change_flag_set,
  input  wire logic [7:0]          external_irq_flag_set,
  // Port pins
  input  wire logic [7:0]          port_b_pins,
  input  wire logic [7:0]          port_c_pins,
  input  wire logic [7:0]          port_d_pins,
  output logic [7:0]               port_b_output,
  output logic [7:0]               port_b_direction,
  output logic [7:0]               port_c_output,
  output logic [7:0]               port_c_direction,
  output logic [7:0]               port_d_output,
  output logic [7:0]               port_d_direction
);

  // ==========================================================
  // Implemented bit masks
  // Zero mask makes the location reserved, except the pin inputs and the w1c flag registers: reads zero, writes dropped
  function automatic logic [7:0] rw_mask(input logic [7:0] a);
    case (a)
      iod_pkg::PORT_B_DIRECTION,
      iod_pkg::PORT_B_OUTPUT,
      iod_pkg::PORT_D_DIRECTION,
      iod_pkg::PORT_D_OUTPUT,
      iod_pkg::NVM_ADDRESS_LOW,
      iod_pkg::NVM_ADDRESS_HIGH,
      iod_pkg::TIMER0_COUNT,
      iod_pkg::TIMER0_COMPARE_A,
      iod_pkg::TIMER0_COMPARE_B,
      iod_pkg::SCRATCH_REGISTER_ONE,
      iod_pkg::SCRATCH_REGISTER_TWO,
      iod_pkg::SERIAL_PERIPH_CONTROL,
      iod_pkg::SERIAL_PERIPH_DATA,
      iod_pkg::COMPARATOR_CTRL_STAT,
      iod_pkg::STACK_POINTER_LOW,
      iod_pkg::CORE_STATUS_FLAGS,
      iod_pkg::WATCHDOG_CTRL_STAT,
      iod_pkg::OSCILLATOR_TRIM,
      iod_pkg::PIN_CHANGE_MASK_0,
      iod_pkg::PIN_CHANGE_MASK_1,
      iod_pkg::PIN_CHANGE_MASK_2:  rw_mask = 8'hFF;
      iod_pkg::PORT_C_DIRECTION,
      iod_pkg::PORT_C_OUTPUT:      rw_mask = 8'h7F;
      iod_pkg::EXTERNAL_IRQ_MASK:  rw_mask = 8'h03;
      iod_pkg::TIMER_GENERAL_CONTROL: rw_mask = 8'h83;
      iod_pkg::TIMER0_CONTROL_A:   rw_mask = 8'hF3;
      iod_pkg::TIMER0_CONTROL_B:   rw_mask = 8'hCF;
      iod_pkg::SERIAL_PERIPH_STATUS: rw_mask = 8'h01;
      iod_pkg::SLEEP_MODE_CONTROL,
      iod_pkg::RESET_CAUSE_STATUS,
      iod_pkg::EXT_IRQ_SENSE_CTRL: rw_mask = 8'h0F;
      iod_pkg::CORE_CONTROL:       rw_mask = 8'h73;
      iod_pkg::SELF_PROGRAM_CONTROL: rw_mask = 8'hDF;
      iod_pkg::STACK_POINTER_HIGH,
      iod_pkg::PIN_CHANGE_IRQ_CTRL,
      iod_pkg::TIMER0_IRQ_MASK,
      iod_pkg::TIMER2_IRQ_MASK:    rw_mask = 8'h07;
      iod_pkg::TIMER1_IRQ_MASK:    rw_mask = 8'h27;
      iod_pkg::CLOCK_PRESCALE:     rw_mask = 8'h8F;
      iod_pkg::POWER_REDUCTION:    rw_mask = 8'hEF;
      default:                     rw_mask = iod_pkg::NO_BITS;
    endcase
  endfunction

  function automatic logic [7:0] w1c_mask(input logic [7:0] a);
    case (a)
      iod_pkg::TIMER0_FLAGS,
      iod_pkg::TIMER2_FLAGS,
      iod_pkg::PIN_CHANGE_FLAGS:   w1c_mask = 8'h07;
      iod_pkg::TIMER1_FLAGS:       w1c_mask = 8'h27;
      iod_pkg::EXTERNAL_IRQ_FLAGS: w1c_mask = 8'h03;
      default:                     w1c_mask = iod_pkg::NO_BITS;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [7:0] pb_meta_q;
  logic [7:0] pc_meta_q;
  logic [7:0] pd_meta_q;
  logic [7:0] pb_sync_q;
  logic [7:0] pc_sync_q;
  logic [7:0] pd_sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pb_meta_q <= iod_pkg::RESET_VALUE;
      pc_meta_q <= iod_pkg::RESET_VALUE;
      pd_meta_q <= iod_pkg::RESET_VALUE;
      pb_sync_q <= iod_pkg::RESET_VALUE;
      pc_sync_q <= iod_pkg::RESET_VALUE;
      pd_sync_q <= iod_pkg::RESET_VALUE;
    end else begin
      pb_meta_q <= port_b_pins;
      pc_meta_q <= port_c_pins;
      pd_meta_q <= port_d_pins;
      pb_sync_q <= pb_meta_q;
      pc_sync_q <= pc_meta_q;
      pd_sync_q <= pd_meta_q;
    end
  end

  // ==========================================================
  // Request decode
  logic       is_port;
  logic       is_bit;
  logic       is_skip;
  logic       accept;
  logic       write_en;
  logic [7:0] dec_addr;
  logic [7:0] wr_en_bits;
  logic [7:0] wr_val_bits;

  always_comb begin
    is_port = (req_kind == iod_pkg::port_read_op) || (req_kind == iod_pkg::port_write_op);
    is_skip = (req_kind == iod_pkg::skip_if_bit_set_op)
           || (req_kind == iod_pkg::skip_if_bit_clear_op);
    is_bit  = is_skip || (req_kind == iod_pkg::bit_set_op)
           || (req_kind == iod_pkg::bit_clear_op);
    if (is_port) begin
      accept = req_addr <= iod_pkg::PORT_LAST;
    end else if (is_bit) begin
      accept = req_addr <= iod_pkg::BIT_LAST;
    end else begin
      accept = req_addr >= iod_pkg::IO_DATA_OFFSET;
    end
    // Port and bit spaces sit one offset below the data space
    dec_addr = (is_port || is_bit) ? 8'(req_addr + iod_pkg::IO_DATA_OFFSET) : req_addr;
    write_en = req_valid && accept
            && ((req_kind == iod_pkg::port_write_op)
             || (req_kind == iod_pkg::data_space_write_op)
             || (req_kind == iod_pkg::bit_set_op)
             || (req_kind == iod_pkg::bit_clear_op));
    if (is_bit) begin
      wr_en_bits = 8'(iod_pkg::ONE_BIT << req_bit);
    end else begin
      wr_en_bits = iod_pkg::ALL_BITS;
    end
    if (req_kind == iod_pkg::bit_set_op) begin
      wr_val_bits = iod_pkg::ALL_BITS;
    end else if (req_kind == iod_pkg::bit_clear_op) begin
      wr_val_bits = iod_pkg::NO_BITS;
    end else begin
      wr_val_bits = req_wdata;
    end
  end

  // ==========================================================
  // Register storage, one entry per data address
  logic [7:0] regs_q [iod_pkg::DATA_IO_BASE:iod_pkg::DATA_LAST];

  for (genvar a = iod_pkg::DATA_IO_BASE; a <= iod_pkg::DATA_LAST; a++) begin : g_reg
    localparam logic [7:0] ADDR = 8'(a);
    localparam logic [7:0] RW   = rw_mask(ADDR);
    localparam logic [7:0] W1C  = w1c_mask(ADDR);
    logic [7:0] hw_set;
    logic [7:0] upd;
    logic [7:0] clr;

    always_comb begin
      case (ADDR)
        iod_pkg::TIMER0_FLAGS:       hw_set = timer0_flag_set;
        iod_pkg::TIMER1_FLAGS:       hw_set = timer1_flag_set;
        iod_pkg::TIMER2_FLAGS:       hw_set = timer2_flag_set;
        iod_pkg::PIN_CHANGE_FLAGS:   hw_set = pin_change_flag_set;
        iod_pkg::EXTERNAL_IRQ_FLAGS: hw_set = external_irq_flag_set;
        default:                     hw_set = iod_pkg::NO_BITS;
      endcase
      upd = (write_en && dec_addr == ADDR) ? (wr_en_bits & RW) : iod_pkg::NO_BITS;
      clr = (write_en && dec_addr == ADDR) ? (wr_en_bits & wr_val_bits & W1C)
                                           : iod_pkg::NO_BITS;
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        regs_q[a] <= iod_pkg::RESET_VALUE;
      end else begin
        regs_q[a] <= ((((regs_q[a] & ~upd) | (wr_val_bits & upd)) & ~clr)
                     | (hw_set & W1C)) & (RW | W1C);
      end
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] cur_val;
  logic       cur_bit;

  always_comb begin
    if (!accept) begin
      cur_val = iod_pkg::NO_BITS;
    end else begin
      case (dec_addr)
        iod_pkg::PORT_B_PIN_INPUT: cur_val = pb_sync_q;
        iod_pkg::PORT_C_PIN_INPUT: cur_val = pc_sync_q & rw_mask(iod_pkg::PORT_C_OUTPUT);
        iod_pkg::PORT_D_PIN_INPUT: cur_val = pd_sync_q;
        default:                   cur_val = regs_q[dec_addr];
      endcase
    end
    cur_bit = cur_val[req_bit];
  end

  // ==========================================================
  // Answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_q  <= 1'b0;
      rsp_rdata_q  <= iod_pkg::RESET_VALUE;
      rsp_skip_q   <= 1'b0;
      rsp_reject_q <= 1'b0;
    end else begin
      rsp_valid_q  <= req_valid;
      rsp_reject_q <= req_valid && !accept;
      rsp_rdata_q  <= req_valid ? cur_val : iod_pkg::RESET_VALUE;
      // Skip when the tested bit matches the polarity asked for
      rsp_skip_q   <= req_valid && accept && is_skip
                   && (cur_bit == (req_kind == iod_pkg::skip_if_bit_set_op));
    end
  end

  assign port_b_output    = regs_q[iod_pkg::PORT_B_OUTPUT];
  assign port_b_direction = regs_q[iod_pkg::PORT_B_DIRECTION];
  assign port_c_output    = regs_q[iod_pkg::PORT_C_OUTPUT];
  assign port_c_direction = regs_q[iod_pkg::PORT_C_DIRECTION];
  assign port_d_output    = regs_q[iod_pkg::PORT_D_OUTPUT];
  assign port_d_direction = regs_q[iod_pkg::PORT_D_DIRECTION];

  // ==========================================================
  // Assertions
  property p_bit_range;
    @(posedge clk) disable iff (!reset_n)
      req_valid && is_bit && req_addr > iod_pkg::BIT_LAST |=> rsp_reject_q && !rsp_skip_q;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op above low range accepted");

  property p_skip;
    @(posedge clk) disable iff (!reset_n)
      req_valid && is_skip
      && req_addr == 8'(iod_pkg::TIMER0_FLAGS - iod_pkg::IO_DATA_OFFSET)
      |=> rsp_skip_q == ($past(regs_q[iod_pkg::TIMER0_FLAGS][req_bit])
                         == $past(req_kind == iod_pkg::skip_if_bit_set_op));
  endproperty
  a_skip: assert property (p_skip) else $error("skip result wrong");

  property p_w1c;
    @(posedge clk) disable iff (!reset_n)
      req_valid && req_kind == iod_pkg::data_space_write_op
      && req_addr == iod_pkg::TIMER0_FLAGS && timer0_flag_set == iod_pkg::NO_BITS
      |=> regs_q[iod_pkg::TIMER0_FLAGS]
          == ($past(regs_q[iod_pkg::TIMER0_FLAGS]) & ~$past(req_wdata));
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag write-one-to-clear wrong");

  property p_bit_only;
    @(posedge clk) disable iff (!reset_n)
      req_valid && (req_kind == iod_pkg::bit_set_op || req_kind == iod_pkg::bit_clear_op)
      && dec_addr == iod_pkg::TIMER1_FLAGS && timer1_flag_set == iod_pkg::NO_BITS
      |=> (regs_q[iod_pkg::TIMER1_FLAGS] & ~$past(wr_en_bits))
          == ($past(regs_q[iod_pkg::TIMER1_FLAGS]) & ~$past(wr_en_bits));
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit op touched other flags");

  property p_port_range;
    @(posedge clk) disable iff (!reset_n)
      req_valid && is_port |=> rsp_reject_q == ($past(req_addr) > iod_pkg::PORT_LAST);
  endproperty
  a_port_range: assert property (p_port_range) else $error("port range decode wrong");

  property p_offset;
    @(posedge clk) disable iff (!reset_n)
      req_valid && req_kind == iod_pkg::port_write_op
      && req_addr == 8'(iod_pkg::PORT_B_DIRECTION - iod_pkg::IO_DATA_OFFSET)
      |=> port_b_direction == $past(req_wdata) && rsp_valid_q && !rsp_reject_q;
  endproperty
  a_offset: assert property (p_offset) else $error("port to data offset wrong");

  property p_extended;
    @(posedge clk) disable iff (!reset_n)
      req_valid && req_kind == iod_pkg::data_space_write_op
      && req_addr == iod_pkg::WATCHDOG_CTRL_STAT
      |=> regs_q[iod_pkg::WATCHDOG_CTRL_STAT] == $past(req_wdata) && !rsp_reject_q;
  endproperty
  a_extended: assert property (p_extended) else $error("extended store lost");

  property p_reserved;
    @(posedge clk) disable iff (!reset_n)
      req_valid && req_kind == iod_pkg::data_space_load && rw_mask(req_addr) == 8'h00
      && w1c_mask(req_addr) == 8'h00 && req_addr != iod_pkg::PORT_B_PIN_INPUT
      && req_addr != iod_pkg::PORT_C_PIN_INPUT && req_addr != iod_pkg::PORT_D_PIN_INPUT
      && req_addr >= iod_pkg::IO_DATA_OFFSET
      |=> rsp_rdata_q == 8'h00 && !rsp_reject_q;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved location not zero");

endmodule

// ---- test/iod_core_model.sv ----
`timescale 1ns/1ps
module iod_core_model (
  // Clock
  input  wire logic                  clk,
  // Request
  output logic                       req_valid,
  output iod_pkg::iod_kind_type      req_kind,
  output logic [7:0]                 req_addr,
  output logic [2:0]                 req_bit,
  output logic [7:0]                 req_wdata,
  // Answer
  input  wire logic                  rsp_valid_q,
  input  wire logic [7:0]            rsp_rdata_q,
  input  wire logic                  rsp_skip_q,
  input  wire logic                  rsp_reject_q
);
  initial begin
    req_valid = 1'b0;
    req_kind  = iod_pkg::port_read_op;
    req_addr  = 8'h00;
    req_bit   = 3'h0;
    req_wdata = 8'h00;
  end

  // ==========================================================
  // One request; the answer is sampled half a cycle into the cycle in which it stands
  task automatic access(input iod_pkg::iod_kind_type k, input logic [7:0] a,
                        input logic [2:0] b, input logic [7:0] d,
                        output logic [7:0] rd, output logic [2:0] st);
    @(negedge clk);
    req_valid = 1'b1;
    req_kind  = k;
    req_addr  = a;
    req_bit   = b;
    req_wdata = d;
    @(negedge clk);
    // Answer lasts one cycle only, so take it before releasing
    rd = rsp_rdata_q;
    st = {rsp_valid_q, rsp_skip_q, rsp_reject_q};
    // Idle qualifiers flip so a stale value never looks live
    req_valid = 1'b0;
    req_addr  = ~a;
    req_bit   = ~b;
    req_wdata = ~d;
  endtask
endmodule

// ---- test/tb_iod_io_register_space_decoder.sv ----
`timescale 1ns/1ps
module tb_iod_io_register_space_decoder;
  // ==========================================================
  // Signals
  logic                  clk = 1'b0;
  logic                  reset_n, req_valid, rsp_valid_q, rsp_skip_q, rsp_reject_q;
  iod_pkg::iod_kind_type req_kind, k;
  logic [2:0]            req_bit, st;
  logic [7:0]            req_addr, req_wdata, rsp_rdata_q, rd, v, a;
  logic [7:0]            port_b_pins, port_c_pins, port_d_pins, port_b_output, port_c_output;
  logic [7:0]            port_d_output, port_b_direction, port_c_direction, port_d_direction;
  logic [7:0]            fset [0:4];
  logic [7:0]            expv [0:8];
  int                    error_cnt = 0, checks = 0, seed = 42515, i, j;
  localparam iod_pkg::iod_kind_type PRD = iod_pkg::port_read_op;
  localparam iod_pkg::iod_kind_type PWR = iod_pkg::port_write_op;
  localparam iod_pkg::iod_kind_type LDD = iod_pkg::data_space_load;
  localparam iod_pkg::iod_kind_type STR = iod_pkg::data_space_write_op;
  localparam iod_pkg::iod_kind_type BST = iod_pkg::bit_set_op;
  localparam iod_pkg::iod_kind_type BCL = iod_pkg::bit_clear_op;
  localparam iod_pkg::iod_kind_type SKS = iod_pkg::skip_if_bit_set_op;
  localparam iod_pkg::iod_kind_type SKC = iod_pkg::skip_if_bit_clear_op;
  localparam iod_pkg::iod_kind_type RKIND [0:3] = '{PRD, LDD, SKS, SKC};
  localparam logic [7:0] FADDR [0:4] = '{8'h35, 8'h36, 8'h37, 8'h3B, 8'h3C};
  localparam logic [7:0] FMASK [0:4] = '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03};
  localparam logic [7:0] RWREG [0:8] = '{8'h24, 8'h25, 8'h2A, 8'h2B, 8'h4A, 8'h46, 8'h5F,
                                         8'h66, 8'h6D};

  always #4 clk = ~clk;

  iod_io_register_space_decoder dut_u (
    .clk, .reset_n, .req_valid, .req_kind, .req_addr, .req_bit, .req_wdata,
    .rsp_valid_q, .rsp_rdata_q, .rsp_skip_q, .rsp_reject_q,
    .timer0_flag_set(fset[0]), .timer1_flag_set(fset[1]), .timer2_flag_set(fset[2]),
    .pin_change_flag_set(fset[3]), .external_irq_flag_set(fset[4]),
    .port_b_pins, .port_c_pins, .port_d_pins, .port_b_output, .port_b_direction,
    .port_c_output, .port_c_direction, .port_d_output, .port_d_direction
  );

  iod_core_model core_u (
    .clk, .req_valid, .req_kind, .req_addr, .req_bit, .req_wdata,
    .rsp_valid_q, .rsp_rdata_q, .rsp_skip_q, .rsp_reject_q
  );

  // ==========================================================
  // Checking helpers
  function automatic logic exp_rej(iod_pkg::iod_kind_type kk, logic [7:0] aa);
    case (kk)
      PRD, PWR: return aa > iod_pkg::PORT_LAST;
      LDD, STR: return aa < iod_pkg::IO_DATA_OFFSET;
      default:  return aa > iod_pkg::BIT_LAST;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ac(input iod_pkg::iod_kind_type kk, input logic [7:0] aa,
                    input logic [2:0] bb, input logic [7:0] dd);
    core_u.access(kk, aa, bb, dd, rd, st);
    chk("answer valid", {7'h00, st[2]}, 8'h01);
  endtask

  task automatic rdc(input string what, input iod_pkg::iod_kind_type kk,
                     input logic [7:0] aa, input logic [7:0] exp);
    ac(kk, aa, 3'h0, 8'h00);
    chk(what, rd, exp);
  endtask

  task automatic give_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Roughly fifty times the expected run
  initial begin
    #(8 * 20000);
    error_cnt++;
    give_verdict();
  end

  // ==========================================================
  // Scenarios
  initial begin
    reset_n = 1'b0;
    {port_b_pins, port_c_pins, port_d_pins} = 24'h000000;
    for (i = 0; i < 5; i++) fset[i] = 8'h00;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    for (i = 0; i < 9; i++) begin
      a = RWREG[i];
      rdc("reset value", LDD, a, 8'h00);
      v = 8'($random(seed));
      if (a < 8'h60) begin
        ac(PWR, a - 8'h20, 3'h0, v);
        rdc("load after port write", LDD, a, v);
        v = 8'($random(seed));
        ac(STR, a, 3'h0, v);
        rdc("port read after store", PRD, a - 8'h20, v);
      end else begin
        ac(PRD, a - 8'h20, 3'h0, 8'h00);
        chk("extended by port", {7'h00, st[0]}, 8'h01);
        ac(STR, a, 3'h0, v);
        rdc("extended load", LDD, a, v);
      end
      expv[i] = v;
    end
    chk("b direction", port_b_direction, expv[0]);
    chk("d output", port_d_output, expv[3]);
    chk("d direction", port_d_direction, expv[2]);
    ac(PWR, 8'h08, 3'h0, 8'hFF);
    chk("c output", port_c_output, 8'h7F);
    ac(STR, 8'h27, 3'h0, 8'hFF);
    chk("c direction", port_c_direction, 8'h7F);
    v = expv[1];
    for (j = 0; j < 8; j++) begin
      v[j] = 1'($random(seed));
      ac(v[j] ? BST : BCL, 8'h05, j[2:0], 8'h00);
      chk("b output after bit op", port_b_output, v);
    end
    ac(BST, 8'h24, 3'h0, 8'h00);
    chk("bit op above range", {7'h00, st[0]}, 8'h01);
    rdc("no write when refused", LDD, 8'h44, 8'h00);
    ac(SKS, 8'h1F, 3'h0, 8'h00);
    chk("skip at top of range", {6'h00, st[1:0]}, 8'h00);
    ac(SKC, 8'h20, 3'h0, 8'h00);
    chk("skip above range", {7'h00, st[0]}, 8'h01);
    ac(PRD, 8'h40, 3'h0, 8'h00);
    chk("port read above range", {7'h00, st[0]}, 8'h01);
    v = 8'($random(seed));
    ac(STR, 8'h60, 3'h0, v);
    rdc("watchdog store", LDD, 8'h60, v);
    for (i = 0; i < 5; i++) begin
      a = FADDR[i] - 8'h20;
      @(negedge clk);
      fset[i] = 8'hFF;
      @(negedge clk);
      fset[i] = 8'h00;
      rdc("flags set", PRD, a, FMASK[i]);
      ac(SKS, a, 3'h0, 8'h00);
      chk("skip on set flag", {7'h00, st[1]}, 8'h01);
      ac(PWR, a, 3'h0, 8'h00);
      rdc("flags after zero", LDD, FADDR[i], FMASK[i]);
      ac(STR, FADDR[i], 3'h0, 8'h01);
      rdc("flags after one", PRD, a, FMASK[i] & 8'hFE);
      ac(BCL, a, 3'h1, 8'h00);
      rdc("flags after bit clear", PRD, a, FMASK[i] & 8'hFE);
      ac(BST, a, 3'h1, 8'h00);
      rdc("flags after bit set", PRD, a, FMASK[i] & 8'hFC);
      ac(SKC, a, 3'h1, 8'h00);
      chk("skip on clear flag", {7'h00, st[1]}, 8'h01);
      ac(SKS, a, 3'h0, 8'h00);
      chk("no skip on clear flag", {7'h00, st[1]}, 8'h00);
      ac(PWR, a, 3'h0, FMASK[i]);
      rdc("flags cleared", LDD, FADDR[i], 8'h00);
    end
    {port_b_pins, port_c_pins, port_d_pins} = 24'($random(seed));
    repeat (3) @(negedge clk);
    rdc("pins b", PRD, 8'h03, port_b_pins);
    rdc("pins c", LDD, 8'h26, port_c_pins & 8'h7F);
    j = $random(seed) & 7;
    ac(SKC, 8'h09, j[2:0], 8'h00);
    chk("skip on pin", {7'h00, st[1]}, {7'h00, ~port_d_pins[j]});
    rdc("reserved location", LDD, 8'h30, 8'h00);
    chk("reserved not refused", {7'h00, st[0]}, 8'h00);
    // Only read kinds here, so no reserved location is ever written
    for (i = 0; i < 60; i++) begin
      k = RKIND[$unsigned($random(seed)) % 4];
      a = 8'($random(seed));
      ac(k, a, a[2:0], 8'h00);
      chk("refusal", {7'h00, st[0]}, {7'h00, exp_rej(k, a)});
      if (st[0] === 1'b1) chk("refused data", rd, 8'h00);
    end
    give_verdict();
  end
endmodule
